/* File: logic/pap_port_a.sv */
// Port A pin control: pull-up disables, break-before-make, alternate-function overrides, APB registers
`timescale 1ns/10ps

// What this block does
// - Global pull-up off bit set disables every port pull-up, whatever direction and output bits say.
// - With break-before-make on, a pin turned to output stays tri-stated one cycle first.
// - Each port has its own pull-up off bit disabling all pull-ups of that port.
// - A port's effective pull-up off is its own bit ORed with the global bit.
// - Reference output enabled with internal reference selected: bit 7 pull-up and driver off.
// - Bit 7 used as external reference input or bypass: pull-up and driver forced off.
// - SPI enabled as slave forces bit 6 (slave select) to input.
// - The far master drives slave select low; slave SPI is active only while low.
// - SPI master: slave select pin direction follows its direction register bit.
// - Slave select forced to input keeps its pull-up following its output bit.
// - SPI clock pin forced input as slave; follows its direction bit as master.
// - SPI clock pin forced to input keeps its pull-up following its output bit.
// - Serial unit data input overrides nothing; software must leave that pin as input.
// - Master-out slave-in pin forced input as slave; follows its direction bit as master.
// - Master-out slave-in pin forced to input keeps its pull-up following its output bit.
// - Pin n feeds pin change interrupt source n for n from 0 to 7.
// - The designated pin is routed to external interrupt source 1.
// - Without override, pull-up is on only for direction 0, output 1, pull-up off 0.
// - Direction override enabled: driver forced off, else the direction bit.
// - Pull-up override enabled: pull-up follows the override value, ignoring the other bits.
module pap_port_a (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pap_pkg::pap_alt_t alt_ctrl,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pullup_en,
  output logic [7:0] pin_change_src,
  output logic ext_irq_src1,
  output logic serial_unit_data_in,
  output logic spi_slave_selected,
  output logic portb_pullup_off,
  output logic portb_break_before_make
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] global_mcu_control_q;
  logic [7:0] port_control_q;
  logic [7:0] porta_dir_q;
  logic [7:0] porta_out_q;
  logic [7:0] bbm_hold_q;
  logic [7:0] bbm_hold_d;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic [7:0] pin_s3_q;
  logic [7:0] pin_val_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  pap_pkg::pap_pad_t pad_q;
  pap_pkg::pap_pad_t pad_d;
  logic [7:0] pin_change_q;
  logic ext_irq1_q;
  logic data_in_q;
  logic ss_active_q;
  logic portb_pud_q;
  logic portb_bbm_q;
  logic access;
  logic wr_en;
  logic [7:0] rd_val;
  logic rd_hit;
  logic global_pud;
  logic porta_pud;
  logic porta_bbm;
  logic spi_slave;
  logic spi_master;
  logic ref_busy;
  logic [7:0] pu_ovr_en;
  logic [7:0] pu_ovr_val;
  logic [7:0] dir_ovr_en;
  logic [7:0] val_ovr_en;
  logic [7:0] val_ovr_val;

  // Address decode, shared by read mux and write strobes
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] offset);
    addr_is = (addr == offset);
  endfunction : addr_is

  // Default pull-up: input direction, output bit one, no disable
  function automatic logic pullup_default(input logic dir, input logic out, input logic global_pullup_off);
    pullup_default = ~dir & out & ~global_pullup_off;
  endfunction : pullup_default

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state: pready rises the cycle after the access phase opens
  assign access = psel & penable & ~pready_q;
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (addr_is(paddr, pap_pkg::GLOBAL_MCU_CONTROL_OFFSET)) begin
      rd_val = global_mcu_control_q;
    end else if (addr_is(paddr, pap_pkg::PORT_CONTROL_OFFSET)) begin
      rd_val = port_control_q;
    end else if (addr_is(paddr, pap_pkg::PORTA_DIR_OFFSET)) begin
      rd_val = porta_dir_q;
    end else if (addr_is(paddr, pap_pkg::PORTA_OUT_OFFSET)) begin
      rd_val = porta_out_q;
    end else if (addr_is(paddr, pap_pkg::PORTA_PIN_OFFSET)) begin
      rd_val = pin_val_q;
    end else if (addr_is(paddr, pap_pkg::PORT_STATUS_OFFSET)) begin
      rd_val = pad_q.pin_oe;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= access;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= access & ~rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (access) begin
      prdata_q <= (pwrite || !rd_hit) ? 32'h00000000 : {24'h000000, rd_val};
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_mcu_control_q <= pap_pkg::GLOBAL_MCU_CONTROL_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, pap_pkg::GLOBAL_MCU_CONTROL_OFFSET)) begin
        global_mcu_control_q <= pwdata[7:0] & pap_pkg::GLOBAL_MCU_CONTROL_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_q <= pap_pkg::PORT_CONTROL_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, pap_pkg::PORT_CONTROL_OFFSET)) begin
        port_control_q <= pwdata[7:0] & pap_pkg::PORT_CONTROL_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_dir_q <= pap_pkg::PORTA_DIR_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, pap_pkg::PORTA_DIR_OFFSET)) begin
        porta_dir_q <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      porta_out_q <= pap_pkg::PORTA_OUT_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, pap_pkg::PORTA_OUT_OFFSET)) begin
        porta_out_q <= pwdata[7:0];
      end
    end
  end

  assign global_pud = global_mcu_control_q[pap_pkg::GLOBAL_PULLUP_OFF_POS];
  assign porta_pud = port_control_q[pap_pkg::PORTA_PULLUP_OFF_POS] | global_pud;
  assign porta_bbm = port_control_q[pap_pkg::PORTA_BBM_POS];

  // ****************************************************************
  // Break-before-make hold
  // ****************************************************************
  // Bits switching input to output by a direction write, held off one cycle
  always_comb begin
    bbm_hold_d = 8'h00;
    if (wr_en && porta_bbm && addr_is(paddr, pap_pkg::PORTA_DIR_OFFSET)) begin
      bbm_hold_d = pwdata[7:0] & ~porta_dir_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bbm_hold_q <= 8'h00;
    end else begin
      bbm_hold_q <= bbm_hold_d;
    end
  end

  // ****************************************************************
  // Pin input synchronisers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= pap_pkg::PIN_SYNC_RESET;
      pin_s2_q <= pap_pkg::PIN_SYNC_RESET;
      pin_s3_q <= pap_pkg::PIN_SYNC_RESET;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // A pin value changes only when the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin_val
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_val_q[gi] <= 1'b0;
        end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_val_q[gi] <= pin_s3_q[gi];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Alternate-function overrides
  // ****************************************************************
  assign spi_slave = alt_ctrl.spi_enable & ~alt_ctrl.spi_master;
  assign spi_master = alt_ctrl.spi_enable & alt_ctrl.spi_master;
  assign ref_busy = (alt_ctrl.refout_enable & alt_ctrl.ref_internal_sel) | alt_ctrl.extref_use;

  // Override enables and values per pin; a cleared enable leaves the plain port registers in charge
  always_comb begin
    pu_ovr_en = 8'h00;
    pu_ovr_val = 8'h00;
    dir_ovr_en = 8'h00;
    val_ovr_en = 8'h00;
    val_ovr_val = 8'h00;
    // SPI slave: select, clock and data in become inputs, pull-ups keep following their output bits
    if (spi_slave) begin
      dir_ovr_en[pap_pkg::SS_PIN] = 1'b1;
      dir_ovr_en[pap_pkg::SCK_PIN] = 1'b1;
      dir_ovr_en[pap_pkg::MOSI_PIN] = 1'b1;
      pu_ovr_en[pap_pkg::SS_PIN] = 1'b1;
      pu_ovr_en[pap_pkg::SCK_PIN] = 1'b1;
      pu_ovr_en[pap_pkg::MOSI_PIN] = 1'b1;
      pu_ovr_val[pap_pkg::SS_PIN] = porta_out_q[pap_pkg::SS_PIN] & ~porta_pud;
      pu_ovr_val[pap_pkg::SCK_PIN] = porta_out_q[pap_pkg::SCK_PIN] & ~porta_pud;
      pu_ovr_val[pap_pkg::MOSI_PIN] = porta_out_q[pap_pkg::MOSI_PIN] & ~porta_pud;
    end
    // SPI master: directions stay with the register, clock and data out carry the SPI values
    if (spi_master) begin
      val_ovr_en[pap_pkg::SCK_PIN] = 1'b1;
      val_ovr_en[pap_pkg::MOSI_PIN] = 1'b1;
      val_ovr_val[pap_pkg::SCK_PIN] = alt_ctrl.sck_out;
      val_ovr_val[pap_pkg::MOSI_PIN] = alt_ctrl.mosi_out;
    end
    // Reference pin: driver and pull-up forced off while the converter uses it
    if (ref_busy) begin
      dir_ovr_en[pap_pkg::REF_PIN] = 1'b1;
      pu_ovr_en[pap_pkg::REF_PIN] = 1'b1;
    end
  end

  // Every direction override of this port forces the pin to input
  always_comb begin
    pad_d = '0;
    for (int i = 0; i < 8; i++) begin
      pad_d.pin_out[i] = val_ovr_en[i] ? val_ovr_val[i] : porta_out_q[i];
      pad_d.pin_oe[i] = dir_ovr_en[i] ? 1'b0 : porta_dir_q[i] & ~bbm_hold_q[i];
      pad_d.pullup_en[i] = pu_ovr_en[i] ? pu_ovr_val[i]
        : pullup_default(porta_dir_q[i], porta_out_q[i], porta_pud);
    end
  end

  // ****************************************************************
  // Pad drive registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_q <= '0;
    end else begin
      pad_q <= pad_d;
    end
  end

  // ****************************************************************
  // Input routing toward interrupt and serial logic
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_change_q <= 8'h00;
    end else begin
      pin_change_q <= pin_val_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq1_q <= 1'b0;
    end else begin
      ext_irq1_q <= pin_val_q[pap_pkg::EXT_IRQ1_PIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_in_q <= 1'b0;
    end else begin
      data_in_q <= pin_val_q[pap_pkg::DATA_IN_PIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_active_q <= 1'b0;
    end else begin
      ss_active_q <= spi_slave & ~pin_val_q[pap_pkg::SS_PIN];
    end
  end

  // ****************************************************************
  // Port B controls
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portb_pud_q <= 1'b0;
    end else begin
      portb_pud_q <= port_control_q[pap_pkg::PORTB_PULLUP_OFF_POS] | global_pud;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      portb_bbm_q <= 1'b0;
    end else begin
      portb_bbm_q <= port_control_q[pap_pkg::PORTB_BBM_POS];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pin_out = pad_q.pin_out;
  assign pin_oe = pad_q.pin_oe;
  assign pullup_en = pad_q.pullup_en;
  assign pin_change_src = pin_change_q;
  assign ext_irq_src1 = ext_irq1_q;
  assign serial_unit_data_in = data_in_q;
  assign spi_slave_selected = ss_active_q;
  assign portb_pullup_off = portb_pud_q;
  assign portb_break_before_make = portb_bbm_q;

endmodule : pap_port_a

/* File: inc/pap_pkg.sv */
// Package with register map, field positions, reset values and carrier types for the port A pin control block
package pap_pkg;

  // ****************************************************************
  // Register map (byte addresses on the APB bus)
  // ****************************************************************
  localparam logic [7:0] GLOBAL_MCU_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] PORT_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] PORTA_DIR_OFFSET = 8'h08;
  localparam logic [7:0] PORTA_OUT_OFFSET = 8'h0c;
  localparam logic [7:0] PORTA_PIN_OFFSET = 8'h10;
  localparam logic [7:0] PORT_STATUS_OFFSET = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int GLOBAL_PULLUP_OFF_POS = 4;
  localparam int PORTA_BBM_POS = 4;
  localparam int PORTB_BBM_POS = 5;
  localparam int PORTA_PULLUP_OFF_POS = 0;
  localparam int PORTB_PULLUP_OFF_POS = 1;
  localparam int REF_PIN = 7;
  localparam int SS_PIN = 6;
  localparam int SCK_PIN = 5;
  localparam int MOSI_PIN = 4;
  localparam int EXT_IRQ1_PIN = 3;
  localparam int DATA_IN_PIN = 4;

  // Writable bits of the two control registers
  localparam logic [7:0] GLOBAL_MCU_CONTROL_MASK = 8'h10;
  localparam logic [7:0] PORT_CONTROL_MASK = 8'h33;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] GLOBAL_MCU_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORTA_DIR_RESET = 8'h00;
  localparam logic [7:0] PORTA_OUT_RESET = 8'h00;
  localparam logic [7:0] PIN_SYNC_RESET = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  // Controls arriving from the SPI and the converter reference logic
  typedef struct packed {
    logic spi_enable;
    logic spi_master;
    logic sck_out;
    logic mosi_out;
    logic refout_enable;
    logic ref_internal_sel;
    logic extref_use;
  } pap_alt_t;

  // Per-port drive state toward the pads
  typedef struct packed {
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pullup_en;
  } pap_pad_t;

endpackage : pap_pkg

/* File: test/pap_port_a_properties.sv */
// Checker of pad, synchroniser and APB timing relations of the port A pin control
`timescale 1ns/10ps
module pap_port_a_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire pap_pkg::pap_alt_t alt_ctrl,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] pin_change_src,
  input wire logic ext_irq_src1,
  input wire logic serial_unit_data_in,
  input wire logic spi_slave_selected
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic slv;
  logic mst;
  logic refo;
  assign slv = alt_ctrl.spi_enable & ~alt_ctrl.spi_master;
  assign mst = alt_ctrl.spi_enable & alt_ctrl.spi_master;
  assign refo = (alt_ctrl.refout_enable & alt_ctrl.ref_internal_sel) | alt_ctrl.extref_use;
  a_no_pull_drive: assert property ((pin_oe & pullup_en) == 8'h00)
    else $error("pull-up on a driven pin");
  a_slave_pins_in: assert property ($past(slv) |-> pin_oe[6:4] == 3'b000)
    else $error("slave pin driven");
  a_ref_pin_off: assert property ($past(refo) |-> !pin_oe[7] && !pullup_en[7])
    else $error("reference pin not released");
  a_sync_pins: assert property ($stable(pin_in) [*8] |-> pin_change_src == pin_in)
    else $error("pin change source wrong");
  a_irq1_route: assert property (ext_irq_src1 == pin_change_src[3])
    else $error("irq source wrong");
  a_data_in_route: assert property (serial_unit_data_in == pin_change_src[4])
    else $error("data input wrong");
  a_ss_select: assert property ($past(presetn) |-> spi_slave_selected == ($past(slv) && !pin_change_src[6]))
    else $error("slave select wrong");
  a_sck_master: assert property ($past(mst) && pin_oe[5] |-> pin_out[5] == $past(alt_ctrl.sck_out))
    else $error("clock pin value wrong");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  c_slave_sel: cover property (spi_slave_selected);
  c_err: cover property (pslverr);
  c_oe_rise: cover property ($rose(pin_oe[0]));
endmodule : pap_port_a_props

bind pap_port_a pap_port_a_props i_props (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .alt_ctrl, .pin_in,
  .pin_out, .pin_oe, .pullup_en, .pin_change_src, .ext_irq_src1, .serial_unit_data_in, .spi_slave_selected);

/* File: test/pap_pad_model.sv */
// Model of the external devices wired to the port A pins
`timescale 1ns/10ps
module pap_pad_model (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_drv,
  output logic [7:0] pin_in
);
  // ****************************************************************
  // Pad resolution
  // ****************************************************************
  logic [7:0] float_q = 8'h00;
  // Undriven pins without pull-up wander every cycle
  always_ff @(posedge pclk) float_q <= ~float_q;
  // Each pin reads its own driver first, then the external driver, then the pull-up, else the wandering value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pullup_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule : pap_pad_model

/* File: test/port_a_pullup_override_test.sv */
// Self-checking testbench of the port A pin control block
`timescale 1ns/10ps
module port_a_pullup_override_test;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq1, sdi, sss, pbo, pbb;
  logic [7:0] paddr, pin_in, pin_out, pin_oe, pullup_en, pcs, ext_val, ext_drv, dv, ov, pc, gb, v;
  logic [31:0] pwdata, prdata, r;
  logic e;
  pap_pkg::pap_alt_t alt;
  int failures = 0, n_checks = 0, seed = 81, cyc = 0;
  pap_port_a i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .alt_ctrl(alt), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .pin_change_src(pcs), .ext_irq_src1(irq1),
    .serial_unit_data_in(sdi), .spi_slave_selected(sss), .portb_pullup_off(pbo), .portb_break_before_make(pbb));
  pap_pad_model i_pads (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .ext_val(ext_val),
    .ext_drv(ext_drv), .pin_in(pin_in));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic chkb(input logic [7:0] g, input logic [7:0] x);
    chk({24'h0, g}, {24'h0, x});
  endtask : chkb
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic settle(input pap_pkg::pap_alt_t a);
    @(posedge pclk);
    alt <= a;
    repeat (6) @(posedge pclk);
    #1;
  endtask : settle
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  function automatic logic [7:0] exp_pu(logic [7:0] d, logic [7:0] o, logic off);
    return ~d & o & {8{~off}};
  endfunction : exp_pu
  // ****************************************************************
  // Clock, timeout and sequence
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    alt = '0;
    ext_val = 8'h00;
    ext_drv = 8'hff;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0);
    chkb(pullup_en, 8'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    for (int k = 0; k < 20; k++) begin
      dv = (k == 0) ? 8'h00 : 8'($random(seed));
      ov = (k == 0) ? 8'hff : 8'($random(seed));
      pc = 8'($random(seed)) & 8'h03;
      gb = (k == 0) ? 8'h10 : 8'($random(seed)) & 8'h10;
      wr(pap_pkg::GLOBAL_MCU_CONTROL_OFFSET, gb);
      wr(pap_pkg::PORT_CONTROL_OFFSET, pc);
      wr(pap_pkg::PORTA_DIR_OFFSET, dv);
      wr(pap_pkg::PORTA_OUT_OFFSET, ov);
      settle(7'h00);
      chkb(pullup_en, exp_pu(dv, ov, pc[0] | gb[4]));
      chkb(pin_oe, dv);
      chkb(pin_out, ov);
      chkb(8'(pbo), 8'(pc[1] | gb[4]));
    end
    $display("test pull-up done");
    wr(pap_pkg::GLOBAL_MCU_CONTROL_OFFSET, 8'h00);
    wr(pap_pkg::PORT_CONTROL_OFFSET, 8'h00);
    wr(pap_pkg::PORTA_DIR_OFFSET, 8'hff);
    wr(pap_pkg::PORTA_OUT_OFFSET, 8'hff);
    settle(7'h40);
    chkb(pin_oe, 8'h8f);
    chkb(pullup_en, 8'h70);
    settle(7'h60);
    chkb(pin_oe, 8'hff);
    chkb(pin_out, 8'hcf);
    settle(7'h06);
    chkb(pin_oe, 8'h7f);
    wr(pap_pkg::PORTA_DIR_OFFSET, 8'h00);
    settle(7'h01);
    chkb(pullup_en, 8'h7f);
    $display("test override done");
    settle(7'h00);
    for (int b = 0; b < 2; b++) begin
      wr(pap_pkg::PORTA_DIR_OFFSET, 8'h00);
      wr(pap_pkg::PORT_CONTROL_OFFSET, b ? 8'h20 : 8'h10);
      settle(7'h00);
      wr(pap_pkg::PORTA_DIR_OFFSET, 8'hff);
      @(posedge pclk);
      #1;
      chkb(pin_oe, b ? 8'hff : 8'h00);
      @(posedge pclk);
      #1;
      chkb(pin_oe, 8'hff);
      chkb(8'(pbb), 8'(b));
    end
    wr(pap_pkg::PORTA_DIR_OFFSET, 8'h00);
    wr(pap_pkg::PORT_CONTROL_OFFSET, 8'h00);
    $display("test break-before-make done");
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 8'hbf : 8'($random(seed));
      ext_val <= v;
      settle(7'h40);
      chkb(pcs, v);
      chkb(8'(irq1), 8'(v[3]));
      chkb(8'(sdi), 8'(v[4]));
      chkb(8'(sss), {7'h00, ~v[6]});
      wr(pap_pkg::PORTA_PIN_OFFSET, ~v);
      rd(pap_pkg::PORTA_PIN_OFFSET, {24'h0, v});
    end
    $display("test inputs done");
    close_out();
  end
endmodule : port_a_pullup_override_test
